/* File: inc/pin_mux_defines.svh */
// Constants of the pin function select and mode pin block.
// Assumes one system clock; bus offsets are byte addresses, haddr[7:0].
// Behaviour
// - Bus clock enable runs at half the clock generator rate.
// - After power-on reset port A bit 5 is a general input.
// - Writing one to reset pin enable makes port A bit 5 the reset input.
// - Reset pin selection cannot be undone by software until next reset.
// - Reset pin driven low while selected resets the whole device.
// - Reset pin enable turns on the port A bit 5 pullup automatically.
// - Port A bit 4 is mode select in reset, debug pin afterwards.
// - Pullup on port A bit 4 while it is debug or mode pin.
// - Clearing background pin enable makes port A bit 4 output only.
// - Mode pin low at reset release enters active background mode.
// - One debug bit time lasts 16 debug controller clocks.
// - Debug controller clock equals the bus clock rate.
// - Debug pin is pseudo open drain with brief driven high speedup.
// - After reset other pins are inputs, pullup and pulldown off.
// - Two-wire bus pins relocate from port B 7/6 to port A 3/2.
// - Timer channels relocate from port B 4/5 to port A 0/1.
// - Mode pin high at reset release gives run mode fetching at 3FFD.
`ifndef PIN_MUX_DEFINES_SVH
`define PIN_MUX_DEFINES_SVH

`define OPT_OFS     8'h00
`define PTA_DAT_OFS 8'h04
`define PTA_DIR_OFS 8'h08
`define PTA_PU_OFS  8'h0C
`define PTA_PD_OFS  8'h10
`define PTB_DAT_OFS 8'h14
`define PTB_DIR_OFS 8'h18
`define PTB_PU_OFS  8'h1C
`define PTB_PD_OFS  8'h20
`define STAT_OFS    8'h24

`define OPT_RPE     0
`define OPT_BGPE    1
`define OPT_IICR    2
`define OPT_TPMR    3
`define OPT_RST     4'h2

`define STAT_DBG    0
`define STAT_RPE    1
`define STAT_PINRST 2

`define BIT_BUS_CYC   5'h10
`define SPEEDUP_CYC   2'h1
`define RST_HOLD_CYC  4'h8
`define FETCH_ADDR    14'h3FFD

`endif

/* File: inc/pin_mux_pkg.sv */
// Types shared by the pin function select block.
// Assumes pin_mux_defines.svh holds the numeric constants.
package pin_mux_pkg;
   typedef enum logic {BOOT_RUN, BOOT_DBG} boot_mode_t;
   typedef enum logic [1:0] {DRV_IDLE, DRV_LOW, DRV_SPEEDUP} drv_state_t;
endpackage

/* File: rtl/bus_tick_gen.sv */
// Bus clock enable and debug bit time tick.
// Assumes clk is the clock generator output.
`timescale 1ns/1ns
`include "pin_mux_defines.svh"
module bus_tick_gen #(
   parameter logic [4:0] BIT_CYC = `BIT_BUS_CYC
) (
   input  wire logic clk_i,
   input  wire logic rst_n_i,
   output logic      bus_en_o,
   output logic      bit_tick_o
);
   logic [4:0] bit_cnt_ff;

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         bus_en_o <= 1'b0;
      end else begin
         bus_en_o <= ~bus_en_o;
      end
   end

   // Debug clock is the bus enable itself, so bit time tracks the bus
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         bit_cnt_ff <= 5'h00;
         bit_tick_o <= 1'b0;
      end else begin
         bit_tick_o <= 1'b0;
         if (bus_en_o) begin
            if (bit_cnt_ff == BIT_CYC - 5'h01) begin
               bit_cnt_ff <= 5'h00;
               bit_tick_o <= 1'b1;
            end else begin
               bit_cnt_ff <= bit_cnt_ff + 5'h01;
            end
         end
      end
   end
endmodule

/* File: rtl/debug_pin_drive.sv */
// Pseudo open drain driver of the background debug pin.
// Assumes the debug controller requests low drive as a level.
`timescale 1ns/1ns
`include "pin_mux_defines.svh"
module debug_pin_drive
   import pin_mux_pkg::*;
(
   input  wire logic clk_i,
   input  wire logic rst_n_i,
   input  wire logic en_i,
   input  wire logic bus_en_i,
   input  wire logic drive_low_i,
   output logic      out_o,
   output logic      oe_o
);
   drv_state_t state_ff;
   logic [1:0] cnt_ff;

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         state_ff <= DRV_IDLE;
         cnt_ff   <= 2'h0;
      end else if (!en_i) begin
         state_ff <= DRV_IDLE;
         cnt_ff   <= 2'h0;
      end else if (bus_en_i) begin
         case (state_ff)
            DRV_IDLE: begin
               if (drive_low_i) begin
                  state_ff <= DRV_LOW;
               end
            end
            DRV_LOW: begin
               if (!drive_low_i) begin
                  state_ff <= DRV_SPEEDUP;
                  cnt_ff   <= `SPEEDUP_CYC;
               end
            end
            DRV_SPEEDUP: begin
               if (cnt_ff == 2'h1) begin
                  state_ff <= DRV_IDLE;
               end
               cnt_ff <= cnt_ff - 2'h1;
            end
            default: state_ff <= DRV_IDLE;
         endcase
      end
   end

   // Pullup alone holds the line high once the speedup pulse ends
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         out_o <= 1'b0;
         oe_o  <= 1'b0;
      end else begin
         out_o <= (state_ff == DRV_SPEEDUP);
         oe_o  <= en_i && (state_ff != DRV_IDLE);
      end
   end
endmodule

/* File: rtl/pin_function_select_and_mode_pin.sv */
// Pin function select, reset pin and mode pin logic with AHB-Lite registers.
// Assumes all pin inputs are synchronous to SYS_CLK_I and peripherals
// present their drive requests as levels.
`timescale 1ns/1ns
`include "pin_mux_defines.svh"
module pin_function_select_and_mode_pin
   import pin_mux_pkg::*;
(
   input  wire logic        SYS_CLK_I,
   input  wire logic        NRST_I,
   input  wire logic        HSEL_I,
   input  wire logic [31:0] HADDR_I,
   input  wire logic [1:0]  HTRANS_I,
   input  wire logic        HWRITE_I,
   input  wire logic [2:0]  HSIZE_I,
   input  wire logic [31:0] HWDATA_I,
   input  wire logic        HREADY_I,
   output logic      [31:0] HRDATA_O,
   output logic             HREADYOUT_O,
   output logic             HRESP_O,
   input  wire logic [5:0]  PTA_IN_I,
   output logic      [5:0]  PTA_OUT_O,
   output logic      [5:0]  PTA_OE_O,
   output logic      [5:0]  PTA_PU_O,
   output logic      [5:0]  PTA_PD_O,
   input  wire logic [7:0]  PTB_IN_I,
   output logic      [7:0]  PTB_OUT_O,
   output logic      [7:0]  PTB_OE_O,
   output logic      [7:0]  PTB_PU_O,
   output logic      [7:0]  PTB_PD_O,
   input  wire logic        IIC_EN_I,
   input  wire logic        IIC_SCL_LOW_I,
   input  wire logic        IIC_SDA_LOW_I,
   output logic             IIC_SCL_IN_O,
   output logic             IIC_SDA_IN_O,
   input  wire logic [1:0]  TCH_EN_I,
   input  wire logic [1:0]  TCH_OUT_I,
   input  wire logic [1:0]  TCH_OE_I,
   output logic      [1:0]  TCH_IN_O,
   input  wire logic        TMCLK_EN_I,
   output logic             TMCLK_O,
   input  wire logic        ACMP_OE_I,
   input  wire logic        ACMP_OUT_I,
   input  wire logic        DBG_DRIVE_LOW_I,
   output logic             DBG_PIN_IN_O,
   output logic             DBG_BIT_TICK_O,
   output logic             BUS_CLK_EN_O,
   output logic             SYS_RESET_N_O,
   output logic             BOOT_DBG_O,
   output logic      [13:0] FETCH_ADDR_O
);
   import pin_mux_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   // Helpers

   function automatic logic [1:0] hi_sel(input logic [3:0] en);
      logic [1:0] s;
      s = 2'h0;
      if (en[3]) begin
         s = 2'h3;
      end else if (en[2]) begin
         s = 2'h2;
      end else if (en[1]) begin
         s = 2'h1;
      end
      return s;
   endfunction

   function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
      return a == ofs;
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // State

   logic [3:0]  opt_ff;
   logic [5:0]  pta_dat_ff;
   logic [5:0]  pta_dir_ff;
   logic [5:0]  pta_pu_ff;
   logic [5:0]  pta_pd_ff;
   logic [7:0]  ptb_dat_ff;
   logic [7:0]  ptb_dir_ff;
   logic [7:0]  ptb_pu_ff;
   logic [7:0]  ptb_pd_ff;
   logic [3:0]  hold_cnt_ff;
   logic        in_reset_ff;
   logic        pin_rst_seen_ff;
   boot_mode_t  boot_ff;
   logic        wr_ph_ff;
   logic [7:0]  wad_ff;
   logic        bus_en;
   logic        bdc_out;
   logic        bdc_oe;
   logic        rst_pin_req;
   logic        soft_rst;
   logic        dbg_en;
   logic        addr_ok;
   logic [31:0] nxt_rdata;
   logic [5:0]  nxt_pta_out;
   logic [5:0]  nxt_pta_oe;
   logic [5:0]  nxt_pta_pu;
   logic [5:0]  nxt_pta_pd;
   logic [7:0]  nxt_ptb_out;
   logic [7:0]  nxt_ptb_oe;
   logic [7:0]  nxt_ptb_pu;
   logic [7:0]  nxt_ptb_pd;

   ////////////////////////////////////////////////////////////////////////
   // Clock enables and debug pin driver

   bus_tick_gen #(
      .BIT_CYC (`BIT_BUS_CYC)
   ) u_tick (
      .clk_i      (SYS_CLK_I),
      .rst_n_i    (NRST_I),
      .bus_en_o   (bus_en),
      .bit_tick_o (DBG_BIT_TICK_O)
   );

   debug_pin_drive u_dbg (
      .clk_i       (SYS_CLK_I),
      .rst_n_i     (NRST_I),
      .en_i        (dbg_en),
      .bus_en_i    (bus_en),
      .drive_low_i (DBG_DRIVE_LOW_I),
      .out_o       (bdc_out),
      .oe_o        (bdc_oe)
   );

   always_ff @(posedge SYS_CLK_I or negedge NRST_I) begin
      if (!NRST_I) begin
         BUS_CLK_EN_O <= 1'b0;
      end else begin
         BUS_CLK_EN_O <= ~bus_en;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Reset pin and mode capture

   assign rst_pin_req = opt_ff[`OPT_RPE] && !PTA_IN_I[5];
   assign soft_rst    = rst_pin_req || (hold_cnt_ff != 4'h0);
   assign dbg_en      = opt_ff[`OPT_BGPE] && !in_reset_ff;

   // Stretched so every block sees the pin reset for several cycles
   always_ff @(posedge SYS_CLK_I or negedge NRST_I) begin
      if (!NRST_I) begin
         hold_cnt_ff   <= 4'h0;
         SYS_RESET_N_O <= 1'b0;
      end else begin
         if (rst_pin_req) begin
            hold_cnt_ff <= `RST_HOLD_CYC;
         end else if (hold_cnt_ff != 4'h0) begin
            hold_cnt_ff <= hold_cnt_ff - 4'h1;
         end
         SYS_RESET_N_O <= !soft_rst;
      end
   end

   always_ff @(posedge SYS_CLK_I or negedge NRST_I) begin
      if (!NRST_I) begin
         in_reset_ff <= 1'b1;
         boot_ff     <= BOOT_RUN;
      end else if (soft_rst) begin
         in_reset_ff <= 1'b1;
      end else if (in_reset_ff) begin
         in_reset_ff <= 1'b0;
         boot_ff     <= PTA_IN_I[4] ? BOOT_RUN : BOOT_DBG;
      end
   end

   // Pin reset leaves this set; power-on reset or writing one to it clears it, so software can tell reset cause
   always_ff @(posedge SYS_CLK_I or negedge NRST_I) begin
      if (!NRST_I) begin
         pin_rst_seen_ff <= 1'b0;
      end else if (rst_pin_req) begin
         pin_rst_seen_ff <= 1'b1;
      end else if (wr_ph_ff && hit(wad_ff, `STAT_OFS)
                   && HWDATA_I[`STAT_PINRST]) begin
         pin_rst_seen_ff <= 1'b0;
      end
   end

   always_ff @(posedge SYS_CLK_I or negedge NRST_I) begin
      if (!NRST_I) begin
         BOOT_DBG_O   <= 1'b0;
         FETCH_ADDR_O <= `FETCH_ADDR;
      end else begin
         BOOT_DBG_O   <= (boot_ff == BOOT_DBG);
         FETCH_ADDR_O <= `FETCH_ADDR;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // AHB-Lite slave, zero wait states

   assign addr_ok = HSEL_I && HTRANS_I[1] && HREADY_I;

   always_ff @(posedge SYS_CLK_I or negedge NRST_I) begin
      if (!NRST_I) begin
         wr_ph_ff    <= 1'b0;
         wad_ff      <= 8'h00;
         HREADYOUT_O <= 1'b1;
         HRESP_O     <= 1'b0;
      end else begin
         wr_ph_ff    <= addr_ok && HWRITE_I;
         wad_ff      <= HADDR_I[7:0];
         HREADYOUT_O <= 1'b1;
         HRESP_O     <= 1'b0;
      end
   end

   always_comb begin
      nxt_rdata = 32'h0000_0000;
      case (HADDR_I[7:0])
         `OPT_OFS:     nxt_rdata[3:0] = opt_ff;
         `PTA_DAT_OFS: nxt_rdata[5:0] = (pta_dat_ff & pta_dir_ff)
                                       | (PTA_IN_I & ~pta_dir_ff);
         `PTA_DIR_OFS: nxt_rdata[5:0] = pta_dir_ff;
         `PTA_PU_OFS:  nxt_rdata[5:0] = pta_pu_ff;
         `PTA_PD_OFS:  nxt_rdata[5:0] = pta_pd_ff;
         `PTB_DAT_OFS: nxt_rdata[7:0] = (ptb_dat_ff & ptb_dir_ff)
                                       | (PTB_IN_I & ~ptb_dir_ff);
         `PTB_DIR_OFS: nxt_rdata[7:0] = ptb_dir_ff;
         `PTB_PU_OFS:  nxt_rdata[7:0] = ptb_pu_ff;
         `PTB_PD_OFS:  nxt_rdata[7:0] = ptb_pd_ff;
         `STAT_OFS: begin
            nxt_rdata[`STAT_DBG]    = (boot_ff == BOOT_DBG);
            nxt_rdata[`STAT_RPE]    = opt_ff[`OPT_RPE];
            nxt_rdata[`STAT_PINRST] = pin_rst_seen_ff;
         end
         default: nxt_rdata = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge SYS_CLK_I or negedge NRST_I) begin
      if (!NRST_I) begin
         HRDATA_O <= 32'h0000_0000;
      end else if (addr_ok && !HWRITE_I) begin
         HRDATA_O <= nxt_rdata;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // System options register

   always_ff @(posedge SYS_CLK_I or negedge NRST_I) begin
      if (!NRST_I) begin
         opt_ff <= `OPT_RST;
      end else if (soft_rst) begin
         opt_ff <= `OPT_RST;
      end else if (wr_ph_ff && hit(wad_ff, `OPT_OFS)) begin
         // Reset enable is set-only: a zero write leaves it alone
         opt_ff[`OPT_RPE]  <= opt_ff[`OPT_RPE] | HWDATA_I[`OPT_RPE];
         opt_ff[`OPT_BGPE] <= HWDATA_I[`OPT_BGPE];
         opt_ff[`OPT_IICR] <= HWDATA_I[`OPT_IICR];
         opt_ff[`OPT_TPMR] <= HWDATA_I[`OPT_TPMR];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Port registers

   always_ff @(posedge SYS_CLK_I or negedge NRST_I) begin
      if (!NRST_I) begin
         pta_dat_ff <= 6'h00;
         pta_dir_ff <= 6'h00;
         pta_pu_ff  <= 6'h00;
         pta_pd_ff  <= 6'h00;
      end else if (soft_rst) begin
         pta_dat_ff <= 6'h00;
         pta_dir_ff <= 6'h00;
         pta_pu_ff  <= 6'h00;
         pta_pd_ff  <= 6'h00;
      end else if (wr_ph_ff) begin
         if (hit(wad_ff, `PTA_DAT_OFS)) pta_dat_ff <= HWDATA_I[5:0];
         if (hit(wad_ff, `PTA_DIR_OFS)) pta_dir_ff <= HWDATA_I[5:0];
         if (hit(wad_ff, `PTA_PU_OFS))  pta_pu_ff  <= HWDATA_I[5:0];
         if (hit(wad_ff, `PTA_PD_OFS))  pta_pd_ff  <= HWDATA_I[5:0];
      end
   end

   always_ff @(posedge SYS_CLK_I or negedge NRST_I) begin
      if (!NRST_I) begin
         ptb_dat_ff <= 8'h00;
         ptb_dir_ff <= 8'h00;
         ptb_pu_ff  <= 8'h00;
         ptb_pd_ff  <= 8'h00;
      end else if (soft_rst) begin
         ptb_dat_ff <= 8'h00;
         ptb_dir_ff <= 8'h00;
         ptb_pu_ff  <= 8'h00;
         ptb_pd_ff  <= 8'h00;
      end else if (wr_ph_ff) begin
         if (hit(wad_ff, `PTB_DAT_OFS)) ptb_dat_ff <= HWDATA_I[7:0];
         if (hit(wad_ff, `PTB_DIR_OFS)) ptb_dir_ff <= HWDATA_I[7:0];
         if (hit(wad_ff, `PTB_PU_OFS))  ptb_pu_ff  <= HWDATA_I[7:0];
         if (hit(wad_ff, `PTB_PD_OFS))  ptb_pd_ff  <= HWDATA_I[7:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Pin function selection

   always_comb begin
      // Port function first; pulls only apply to input pins
      nxt_pta_out = pta_dat_ff;
      nxt_pta_oe  = pta_dir_ff;
      nxt_pta_pu  = pta_pu_ff & ~pta_dir_ff;
      nxt_pta_pd  = pta_pd_ff & ~pta_dir_ff;
      nxt_ptb_out = ptb_dat_ff;
      nxt_ptb_oe  = ptb_dir_ff;
      nxt_ptb_pu  = ptb_pu_ff & ~ptb_dir_ff;
      nxt_ptb_pd  = ptb_pd_ff & ~ptb_dir_ff;

      // Two-wire bus pins are open drain: drive low or release
      if (IIC_EN_I) begin
         if (opt_ff[`OPT_IICR]) begin
            nxt_pta_out[3] = 1'b0;
            nxt_pta_oe[3]  = IIC_SCL_LOW_I;
            nxt_pta_out[2] = 1'b0;
            nxt_pta_oe[2]  = IIC_SDA_LOW_I;
         end else begin
            nxt_ptb_out[7] = 1'b0;
            nxt_ptb_oe[7]  = IIC_SCL_LOW_I;
            nxt_ptb_out[6] = 1'b0;
            nxt_ptb_oe[6]  = IIC_SDA_LOW_I;
         end
      end

      for (int c = 0; c < 2; c++) begin
         if (TCH_EN_I[c]) begin
            if (opt_ff[`OPT_TPMR]) begin
               nxt_pta_out[c] = TCH_OUT_I[c];
               nxt_pta_oe[c]  = TCH_OE_I[c];
            end else begin
               nxt_ptb_out[4 + c] = TCH_OUT_I[c];
               nxt_ptb_oe[4 + c]  = TCH_OE_I[c];
            end
         end
      end

      // Port A bit 4: output port, comparator, debug, mode select
      case (hi_sel({in_reset_ff, dbg_en, ACMP_OE_I, 1'b1}))
         2'h3: begin
            nxt_pta_out[4] = 1'b0;
            nxt_pta_oe[4]  = 1'b0;
            nxt_pta_pu[4]  = 1'b1;
            nxt_pta_pd[4]  = 1'b0;
         end
         2'h2: begin
            nxt_pta_out[4] = bdc_out;
            nxt_pta_oe[4]  = bdc_oe;
            nxt_pta_pu[4]  = 1'b1;
            nxt_pta_pd[4]  = 1'b0;
         end
         2'h1: begin
            nxt_pta_out[4] = ACMP_OUT_I;
            nxt_pta_oe[4]  = 1'b1;
            nxt_pta_pu[4]  = 1'b0;
            nxt_pta_pd[4]  = 1'b0;
         end
         default: begin
            nxt_pta_out[4] = pta_dat_ff[4];
            nxt_pta_oe[4]  = 1'b1;
            nxt_pta_pu[4]  = 1'b0;
            nxt_pta_pd[4]  = 1'b0;
         end
      endcase

      // Port A bit 5 is input only: port, timer clock, reset
      nxt_pta_out[5] = 1'b0;
      nxt_pta_oe[5]  = 1'b0;
      nxt_pta_pu[5]  = pta_pu_ff[5];
      nxt_pta_pd[5]  = pta_pd_ff[5];
      if (hi_sel({1'b0, opt_ff[`OPT_RPE], TMCLK_EN_I, 1'b1}) == 2'h2) begin
         nxt_pta_pu[5] = 1'b1;
         nxt_pta_pd[5] = 1'b0;
      end
   end

   always_ff @(posedge SYS_CLK_I or negedge NRST_I) begin
      if (!NRST_I) begin
         PTA_OUT_O <= 6'h00;
         PTA_OE_O  <= 6'h00;
         PTA_PU_O  <= 6'h10;
         PTA_PD_O  <= 6'h00;
         PTB_OUT_O <= 8'h00;
         PTB_OE_O  <= 8'h00;
         PTB_PU_O  <= 8'h00;
         PTB_PD_O  <= 8'h00;
      end else begin
         PTA_OUT_O <= nxt_pta_out;
         PTA_OE_O  <= nxt_pta_oe;
         PTA_PU_O  <= nxt_pta_pu;
         PTA_PD_O  <= nxt_pta_pd;
         PTB_OUT_O <= nxt_ptb_out;
         PTB_OE_O  <= nxt_ptb_oe;
         PTB_PU_O  <= nxt_ptb_pu;
         PTB_PD_O  <= nxt_ptb_pd;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Pin levels back to peripherals

   always_ff @(posedge SYS_CLK_I or negedge NRST_I) begin
      if (!NRST_I) begin
         IIC_SCL_IN_O <= 1'b1;
         IIC_SDA_IN_O <= 1'b1;
         TCH_IN_O     <= 2'h0;
         TMCLK_O      <= 1'b0;
         DBG_PIN_IN_O <= 1'b1;
      end else begin
         IIC_SCL_IN_O <= opt_ff[`OPT_IICR] ? PTA_IN_I[3] : PTB_IN_I[7];
         IIC_SDA_IN_O <= opt_ff[`OPT_IICR] ? PTA_IN_I[2] : PTB_IN_I[6];
         TCH_IN_O     <= opt_ff[`OPT_TPMR] ? PTA_IN_I[1:0] : PTB_IN_I[5:4];
         // Reset function outranks the timer clock on bit 5
         TMCLK_O      <= TMCLK_EN_I && !opt_ff[`OPT_RPE] && PTA_IN_I[5];
         DBG_PIN_IN_O <= dbg_en ? PTA_IN_I[4] : 1'b1;
      end
   end
endmodule

/* File: tb/pin_mux_pod.sv */
// Reset source and debug pod at the far side of port A bits 5 and 4.
// Assumes the bench commands when each line is pulled low or held high.
`timescale 1ns/1ns
module pin_mux_pod (
   input  wire logic clk_i,
   input  wire logic lo5_i,
   input  wire logic hi5_i,
   input  wire logic lo4_i,
   input  wire logic pu5_i,
   input  wire logic pu4_i,
   input  wire logic oe4_i,
   input  wire logic out4_i,
   output logic      pin5_o,
   output logic      pin4_o
);
   logic flt_ff = 1'b0;
   // An unheld line wanders every cycle, so a missing pullup shows up
   always_ff @(posedge clk_i) begin
      flt_ff <= ~flt_ff;
   end
   assign pin5_o = lo5_i ? 1'b0 : ((pu5_i | hi5_i) ? 1'b1 : flt_ff);
   // Pseudo open drain: device drive wins, then the pod, then the pullup
   assign pin4_o = oe4_i ? out4_i : (lo4_i ? 1'b0 : (pu4_i ? 1'b1 : ~flt_ff));
endmodule

/* File: tb/pin_mux_sva.sv */
// Port checker of the pin function select block.
// Assumes the pod keeps the mode pin steady around reset release.
`timescale 1ns/1ns
module pin_mux_sva (
   input wire logic        SYS_CLK_I,
   input wire logic        NRST_I,
   input wire logic [5:0]  PTA_IN_I,
   input wire logic [5:0]  PTA_OE_O,
   input wire logic [5:0]  PTA_PU_O,
   input wire logic        DBG_BIT_TICK_O,
   input wire logic        BUS_CLK_EN_O,
   input wire logic        SYS_RESET_N_O,
   input wire logic        BOOT_DBG_O,
   input wire logic [13:0] FETCH_ADDR_O
);
   default clocking @(posedge SYS_CLK_I); endclocking
   default disable iff (!NRST_I);
   a_bus_half_rate: assert property (BUS_CLK_EN_O |=> !BUS_CLK_EN_O ##1 BUS_CLK_EN_O)
      else $error("bus enable not half rate");
   a_tick_period: assert property (DBG_BIT_TICK_O |-> ##32 DBG_BIT_TICK_O)
      else $error("bit tick period wrong");
   a_tick_single: assert property (DBG_BIT_TICK_O |=> !DBG_BIT_TICK_O [*8])
      else $error("bit tick too long");
   a_pin5_input: assert property (!PTA_OE_O[5])
      else $error("port A bit 5 driven");
   a_mode_pull: assert property (!SYS_RESET_N_O && !$past(SYS_RESET_N_O)
      |-> PTA_PU_O[4] && !PTA_OE_O[4])
      else $error("mode pin not pulled input");
   a_boot_background_debug_pin: assert property ($rose(SYS_RESET_N_O) && !$past(PTA_IN_I[4])
      |-> ##[1:2] BOOT_DBG_O)
      else $error("background mode missed");
   a_boot_run: assert property ($rose(SYS_RESET_N_O) && $past(PTA_IN_I[4])
      |-> ##2 !BOOT_DBG_O)
      else $error("run mode missed");
   a_pin_reset: assert property (PTA_PU_O[5] && !PTA_IN_I[5] && SYS_RESET_N_O
      |=> !SYS_RESET_N_O)
      else $error("pin reset missed");
   a_reset_hold: assert property ($fell(SYS_RESET_N_O) |-> !SYS_RESET_N_O [*8])
      else $error("pin reset too short");
   a_fetch_addr: assert property (FETCH_ADDR_O == 14'h3FFD)
      else $error("fetch address wrong");
endmodule
bind pin_function_select_and_mode_pin pin_mux_sva sva_i (.*);

/* File: tb/test_pin_function_select_and_mode_pin.sv */
// Bench of the pin function select block with its reset source and pod.
// Assumes a zero wait AHB-Lite slave; pins settle one edge after cause.
`timescale 1ns/1ns
`include "pin_mux_defines.svh"
module test_pin_function_select_and_mode_pin;
   logic        SYS_CLK_I = 1'b0, NRST_I = 1'b0, HSEL_I = 1'b1, HWRITE_I = 1'b0;
   logic [31:0] HADDR_I = 32'h0, HWDATA_I = 32'h0, rd;
   logic [1:0]  HTRANS_I = 2'h0, TCH_EN_I = 2'h0, TCH_OUT_I = 2'h0, TCH_OE_I = 2'h0;
   logic [2:0]  HSIZE_I = 3'h2;
   logic [7:0]  PTB_IN_I = 8'hA5;
   logic        IIC_EN_I = 1'b0, IIC_SCL_LOW_I = 1'b0, IIC_SDA_LOW_I = 1'b0, TMCLK_EN_I = 1'b0;
   logic        ACMP_OE_I = 1'b0, ACMP_OUT_I = 1'b0, DBG_DRIVE_LOW_I = 1'b0;
   logic        lo5 = 1'b0, hi5 = 1'b1, lo4 = 1'b0;
   wire         HREADY_I, HREADYOUT_O, HRESP_O, IIC_SCL_IN_O, IIC_SDA_IN_O, TMCLK_O, pin5, pin4;
   wire         DBG_PIN_IN_O, DBG_BIT_TICK_O, BUS_CLK_EN_O, SYS_RESET_N_O, BOOT_DBG_O;
   wire [31:0]  HRDATA_O;
   wire [5:0]   PTA_IN_I, PTA_OUT_O, PTA_OE_O, PTA_PU_O, PTA_PD_O;
   wire [7:0]   PTB_OUT_O, PTB_OE_O, PTB_PU_O, PTB_PD_O;
   wire [1:0]   TCH_IN_O;
   wire [13:0]  FETCH_ADDR_O;
   int          bad_count = 0, check_count = 0, n;
   assign HREADY_I = HREADYOUT_O;
   assign PTA_IN_I = {pin5, pin4, 4'h5};
   always #2 SYS_CLK_I = ~SYS_CLK_I;
   pin_function_select_and_mode_pin uut (.*);
   pin_mux_pod pod (.clk_i(SYS_CLK_I), .lo5_i(lo5), .hi5_i(hi5), .lo4_i(lo4),
      .pu5_i(PTA_PU_O[5]), .pu4_i(PTA_PU_O[4]), .oe4_i(PTA_OE_O[4]),
      .out4_i(PTA_OUT_O[4]), .pin5_o(pin5), .pin4_o(pin4));
   ////////////////////////////////////////////////////////////////////////////
   task automatic results;
      $display("checks %0d mismatches %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         bad_count++;
         $display("Error at %0t: got %0h expected %0h", $time, got, exp);
      end
   endtask
   task automatic lim;
      if (n >= 60) begin
         bad_count++;
         $display("Error at %0t: wait ran out", $time);
         results();
      end
   endtask
   task automatic cyc(input int k);
      repeat (k) @(posedge SYS_CLK_I);
   endtask
   // Address phase, then data phase; each held until ready is seen high
   task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
      HTRANS_I <= 2'h2;
      HADDR_I <= {24'h0, a};
      HWRITE_I <= w;
      n = 0;
      repeat (2) begin
         do begin
            cyc(1);
            n++;
         end while (HREADY_I !== 1'b1 && n < 60);
         HTRANS_I <= 2'h0;
         HWDATA_I <= d;
      end
      rd = HRDATA_O;
      lim();
      cyc(2);
   endtask
   ////////////////////////////////////////////////////////////////////////////
   task automatic t_defaults;
      chk({PTA_OE_O, PTA_PU_O}, 12'h010);
      chk({PTA_PD_O, PTB_OE_O, PTB_PU_O, PTB_PD_O}, 30'h0);
      ahb(1'b0, `OPT_OFS, 32'h0);
      chk(rd, 32'h2);
      ahb(1'b0, 8'h3C, 32'h0);
      chk(rd, 32'h0);
      chk(HRESP_O, 1'b0);
      ahb(1'b1, `PTB_PU_OFS, 32'hFF);
      chk(PTB_PU_O, 8'hFF);
      $display("defaults done");
   endtask
   task automatic t_remap;
      IIC_EN_I <= 1'b1;
      IIC_SCL_LOW_I <= 1'b1;
      TCH_EN_I <= 2'h3;
      TCH_OE_I <= 2'h3;
      TCH_OUT_I <= 2'h1;
      cyc(3);
      chk({PTB_OE_O[7:4], PTB_OUT_O[5:4], IIC_SCL_IN_O, IIC_SDA_IN_O, TCH_IN_O}, 10'h2DA);
      ahb(1'b1, `OPT_OFS, 32'hE);
      chk({PTA_OE_O[3:0], PTA_OUT_O[1:0], IIC_SCL_IN_O, IIC_SDA_IN_O, TCH_IN_O}, 10'h2D5);
      chk(PTB_OE_O[7:4], 4'h0);
      IIC_EN_I <= 1'b0;
      TCH_EN_I <= 2'h0;
      ahb(1'b1, `OPT_OFS, 32'h2);
      $display("remap done");
   endtask
   task automatic t_out_only;
      ACMP_OE_I <= 1'b1;
      ACMP_OUT_I <= 1'b1;
      cyc(3);
      chk(PTA_OE_O[4], 1'b0);
      ahb(1'b1, `OPT_OFS, 32'h0);
      chk({PTA_OE_O[4], PTA_OUT_O[4]}, 2'h3);
      ACMP_OE_I <= 1'b0;
      ahb(1'b1, `PTA_DAT_OFS, 32'h0);
      chk({PTA_OE_O[4], PTA_OUT_O[4], DBG_PIN_IN_O}, 3'h5);
      ahb(1'b1, `OPT_OFS, 32'h2);
      $display("output only done");
   endtask
   task automatic t_debug;
      DBG_DRIVE_LOW_I <= 1'b1;
      cyc(6);
      chk({PTA_OE_O[4], PTA_OUT_O[4], DBG_PIN_IN_O}, 3'h4);
      DBG_DRIVE_LOW_I <= 1'b0;
      for (n = 0; n < 60 && PTA_OUT_O[4] !== 1'b1; n++)
         cyc(1);
      lim();
      for (n = 0; n < 8 && PTA_OE_O[4] === 1'b1; n++)
         cyc(1);
      chk(32'(n), 32'd2);
      cyc(2);
      chk(DBG_PIN_IN_O, 1'b1);
      for (n = 0; n < 60 && DBG_BIT_TICK_O !== 1'b1; n++)
         cyc(1);
      lim();
      for (n = 1; n < 60; n++) begin
         cyc(1);
         if (DBG_BIT_TICK_O === 1'b1)
            break;
      end
      chk(32'(n), 32'd32);
      $display("debug pin done");
   endtask
   task automatic t_pin_reset;
      TMCLK_EN_I <= 1'b1;
      cyc(3);
      chk(TMCLK_O, 1'b1);
      lo5 <= 1'b1;
      cyc(3);
      chk({SYS_RESET_N_O, TMCLK_O}, 2'h2);
      lo5 <= 1'b0;
      ahb(1'b1, `OPT_OFS, 32'h3);
      chk({TMCLK_O, PTA_PU_O[5]}, 2'h1);
      ahb(1'b1, `OPT_OFS, 32'h2);
      chk(PTA_PU_O[5], 1'b1);
      hi5 <= 1'b0;
      lo5 <= 1'b1;
      cyc(3);
      chk(SYS_RESET_N_O, 1'b0);
      lo5 <= 1'b0;
      hi5 <= 1'b1;
      for (n = 0; n < 60 && SYS_RESET_N_O !== 1'b1; n++)
         cyc(1);
      lim();
      chk(32'(n > 7), 32'h1);
      cyc(3);
      ahb(1'b0, `OPT_OFS, 32'h0);
      chk({rd[30:0], PTA_PU_O[5]}, 32'h4);
      ahb(1'b0, `STAT_OFS, 32'h0);
      chk(rd[2:1], 2'h2);
      ahb(1'b1, `STAT_OFS, 32'h4);
      ahb(1'b0, `STAT_OFS, 32'h0);
      chk(rd[2], 1'b0);
      TMCLK_EN_I <= 1'b0;
      $display("pin reset done");
   endtask
   task automatic t_boot;
      lo4 <= 1'b1;
      NRST_I <= 1'b0;
      cyc(12);
      NRST_I <= 1'b1;
      cyc(4);
      lo4 <= 1'b0;
      chk(BOOT_DBG_O, 1'b1);
      ahb(1'b0, `STAT_OFS, 32'h0);
      chk(rd[0], 1'b1);
      $display("boot mode done");
   endtask
   initial begin
      cyc(12);
      NRST_I <= 1'b1;
      cyc(3);
      t_defaults();
      t_remap();
      t_out_only();
      t_debug();
      t_pin_reset();
      t_boot();
      results();
   end
endmodule
